// >>> core/sfram_defs.svh
// Address map, parameter-space layout and timing constants for the flash map core
`ifndef SFRAM_DEFS_SVH
`define SFRAM_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFRAM_CLOCK_PERIOD_NS 50
`define SFRAM_RESET_LOW_MIN_NS 1000
`define SFRAM_RESET_LOW_CYCLES ((`SFRAM_RESET_LOW_MIN_NS + `SFRAM_CLOCK_PERIOD_NS - 1) / `SFRAM_CLOCK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Main array geometry
// ----------------------------------------------------------------------------
`define SFRAM_ADDR_W 24
`define SFRAM_BLOCK_COUNT 256
`define SFRAM_SECTOR_COUNT 4096
`define SFRAM_PAGE_COUNT 65536
`define SFRAM_PAGE_BYTES 256
`define SFRAM_SECTOR_LSB 12
`define SFRAM_BLOCK_LSB 16
`define SFRAM_PAGE_LSB 8

// ----------------------------------------------------------------------------
// Security regions and parameter space
// ----------------------------------------------------------------------------
`define SFRAM_REGION_BYTES 1024
`define SFRAM_REGION_OFS_W 10
`define SFRAM_REGION_FIRST 2'h1
`define SFRAM_REGION_LAST 2'h3
`define SFRAM_PARAM_HDR_BASE 8'h00
`define SFRAM_PARAM_HDR_RSVD 8'h20
`define SFRAM_PARAM_TABLE_BASE 8'h30
`define SFRAM_PARAM_LAST 8'h7b
`define SFRAM_READ_PARAMETERS_CMD 8'h5a
`define SFRAM_ERASED_BYTE 8'hff

`endif

// >>> core/sfram_pkg.sv
// Types shared by the flash map core and its users
package sfram_pkg;

  typedef enum logic [3:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE_SECTOR,
    OP_ERASE_BLOCK,
    OP_ERASE_CHIP,
    OP_ERASE_PAGE,
    OP_SEC_READ,
    OP_SEC_PROGRAM,
    OP_SEC_ERASE,
    OP_SEC_LOCK,
    OP_PARAM_READ
  } sfram_opkind_e;

  typedef enum logic [1:0] {
    ERASE_SECTOR,
    ERASE_BLOCK,
    ERASE_CHIP
  } sfram_erase_e;

  typedef enum logic [1:0] {
    ST_DESELECTED,
    ST_SELECTED,
    ST_RESET_HELD,
    ST_WAIT_DESELECT
  } sfram_state_e;

endpackage

// >>> core/sfram_core.sv
// Reset/hold pin handling and address map of a serial NOR flash
`timescale 1ns/1ps
`include "sfram_defs.svh"

module sfram_core
  import sfram_pkg::*;
#(
  parameter int RESET_LOW_CYCLES = `SFRAM_RESET_LOW_CYCLES,
  parameter logic [7:0] PARAM_TABLE_FILL = 8'hff,
  parameter logic [7:0] PARAM_VENDOR_ID = 8'h00 // Arbitrary value
) (
  input wire logic clock, // System clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic csN, // Chip select, active low
  input wire logic dataLineThreeIn, // Level on data line three
  input wire logic cfgWrite, // Strobe loading the two config bits
  input wire logic cfgResetPinSelect, // New reset_pin_select value
  input wire logic cfgQuadEnable, // New quad_enable_bit value
  input wire logic opValid, // Operation request
  input sfram_opkind_e opKind, // Operation kind
  input wire logic [23:0] opAddr, // Byte address of the operation
  input wire logic [7:0] opData, // Program data
  output logic opReady, // Request taken when high with opValid
  output logic respValid, // Operation answer pulse
  output logic [7:0] respData, // Read data
  output logic respError, // Operation refused
  output logic [23:0] arrayAddr, // Main array address
  input wire logic [7:0] arrayRdData, // Main array byte at arrayAddr
  output logic arrayWrEn, // Main array byte write pulse
  output logic [7:0] arrayWrData, // Byte to store
  output logic arrayErase, // Main array erase pulse
  output sfram_erase_e arrayEraseKind, // Erase granularity
  output logic [7:0] arrayBlock, // Block index of arrayAddr
  output logic [11:0] arraySector, // Sector index of arrayAddr
  output logic [15:0] arrayPage, // Page index of arrayAddr
  output logic abortPulse, // Abort every operation
  output logic holdActive, // Hold in force
  output logic dataOutEn, // Data output may be driven
  output logic busy, // Internal region erase running
  output logic [3:1] lockState, // Region lock bits
  output logic resetPinSelect, // Current reset_pin_select
  output logic quadEnable // Current quad_enable_bit
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic regionAddrOk(input logic [23:0] a);
    return a[23:14] == 10'h000 && a[13:12] >= `SFRAM_REGION_FIRST && a[11:10] == 2'h0;
  endfunction

  function automatic logic [11:0] secIndex(input logic [23:0] a);
    return {a[13:12] - 2'h1, a[9:0]};
  endfunction

  function automatic logic [7:0] paramByte(input logic [7:0] a);
    logic [7:0] v;
    v = `SFRAM_ERASED_BYTE;
    if (a >= `SFRAM_PARAM_TABLE_BASE && a <= `SFRAM_PARAM_LAST) begin
      v = PARAM_TABLE_FILL;
    end else if (a < `SFRAM_PARAM_HDR_RSVD) begin
      unique case (a)
        8'h00: v = 8'h53;
        8'h01: v = 8'h46;
        8'h02: v = 8'h44;
        8'h03: v = 8'h50;
        8'h04: v = 8'h08;
        8'h05: v = 8'h01;
        8'h06: v = 8'h01;
        8'h08: v = 8'h00;
        8'h09: v = 8'h07;
        8'h0a: v = 8'h01;
        8'h0b: v = 8'h10;
        8'h0c: v = 8'h30;
        8'h0d: v = 8'h00;
        8'h0e: v = 8'h00;
        8'h10: v = PARAM_VENDOR_ID;
        8'h11: v = 8'h00;
        8'h12: v = 8'h01;
        8'h13: v = 8'h03;
        8'h14: v = 8'h70;
        8'h15: v = 8'h00;
        8'h16: v = 8'h00;
        default: v = `SFRAM_ERASED_BYTE;
      endcase
    end
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Pin function and configuration
  // --------------------------------------------------------------------------
  logic resetPinSelect_reg;
  logic quadEnable_reg;
  logic hwResetLow;
  logic [15:0] resetLowCnt_reg;
  logic resetFire;
  sfram_state_e state_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      resetPinSelect_reg <= 1'b0;
      quadEnable_reg <= 1'b0;
    end else if (cfgWrite) begin
      resetPinSelect_reg <= cfgResetPinSelect;
      quadEnable_reg <= cfgQuadEnable;
    end
  end

  assign resetPinSelect = resetPinSelect_reg;
  assign quadEnable = quadEnable_reg;
  // Quad mode takes the line as pure data, so neither function may see it
  assign hwResetLow = !quadEnable_reg && resetPinSelect_reg && !dataLineThreeIn;
  assign holdActive = !quadEnable_reg && !resetPinSelect_reg && !dataLineThreeIn && !csN;

  // Counts the low time; a glitch shorter than the minimum restarts the count
  always_ff @(posedge clock) begin
    if (rst || !hwResetLow) begin
      resetLowCnt_reg <= 16'h0000;
    end else if (resetLowCnt_reg != 16'hffff) begin
      resetLowCnt_reg <= resetLowCnt_reg + 16'h0001;
    end
  end

  assign resetFire = hwResetLow && resetLowCnt_reg == 16'(RESET_LOW_CYCLES - 1);

  always_ff @(posedge clock) begin
    if (rst) begin
      abortPulse <= 1'b0;
    end else begin
      abortPulse <= resetFire;
    end
  end

  // --------------------------------------------------------------------------
  // Select state
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_WAIT_DESELECT;
    end else if (resetFire) begin
      state_reg <= ST_RESET_HELD;
    end else begin
      unique case (state_reg)
        ST_DESELECTED: if (!csN) state_reg <= ST_SELECTED;
        ST_SELECTED: if (csN) state_reg <= ST_DESELECTED;
        ST_RESET_HELD: if (!hwResetLow) state_reg <= ST_WAIT_DESELECT;
        ST_WAIT_DESELECT: if (csN) state_reg <= ST_DESELECTED;
      endcase
    end
  end

  assign dataOutEn = state_reg == ST_SELECTED && !csN && !holdActive && !hwResetLow;
  assign opReady = dataOutEn && !busy;

  // --------------------------------------------------------------------------
  // Request decode and pipeline
  // --------------------------------------------------------------------------
  logic [7:0] secMem [0:3*`SFRAM_REGION_BYTES-1];
  logic [3:1] lock_reg;
  logic stageValid_reg;
  sfram_opkind_e stageKind_reg;
  logic [7:0] stageData_reg;
  logic stageError_reg;
  logic [23:0] arrayAddr_reg;
  logic reqError;
  logic inParam;
  logic regionLocked;

  assign inParam = opAddr[23:8] == 16'h0000;
  assign regionLocked = regionAddrOk(opAddr) && lock_reg[opAddr[13:12]];

  always_comb begin
    reqError = 1'b0;
    unique case (opKind)
      OP_ERASE_PAGE: reqError = 1'b1;
      OP_SEC_READ: reqError = !regionAddrOk(opAddr);
      OP_SEC_PROGRAM, OP_SEC_ERASE: reqError = !regionAddrOk(opAddr) || regionLocked;
      OP_SEC_LOCK: reqError = !regionAddrOk(opAddr);
      OP_PARAM_READ: reqError = !inParam;
      default: reqError = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst || resetFire) begin
      stageValid_reg <= 1'b0;
      stageKind_reg <= OP_READ;
      stageData_reg <= 8'h00;
      stageError_reg <= 1'b0;
      arrayAddr_reg <= 24'h000000;
    end else begin
      stageValid_reg <= opValid && opReady;
      if (opValid && opReady) begin
        stageKind_reg <= opKind;
        stageData_reg <= opData;
        stageError_reg <= reqError;
        arrayAddr_reg <= opAddr;
      end
    end
  end

  assign arrayAddr = arrayAddr_reg;
  assign arrayBlock = arrayAddr_reg[23:`SFRAM_BLOCK_LSB];
  assign arraySector = arrayAddr_reg[23:`SFRAM_SECTOR_LSB];
  assign arrayPage = arrayAddr_reg[23:`SFRAM_PAGE_LSB];

  // --------------------------------------------------------------------------
  // Answers and main array commands
  // --------------------------------------------------------------------------
  logic stageGo;
  assign stageGo = stageValid_reg && !stageError_reg && !resetFire;

  always_ff @(posedge clock) begin
    if (rst || resetFire) begin
      respValid <= 1'b0;
      respError <= 1'b0;
      respData <= 8'h00;
      arrayWrEn <= 1'b0;
      arrayWrData <= 8'h00;
      arrayErase <= 1'b0;
      arrayEraseKind <= ERASE_SECTOR;
    end else begin
      respValid <= stageValid_reg;
      respError <= stageValid_reg && stageError_reg;
      arrayWrEn <= stageGo && stageKind_reg == OP_PROGRAM;
      arrayWrData <= arrayRdData & stageData_reg;
      arrayErase <= stageGo && stageKind_reg inside {OP_ERASE_SECTOR, OP_ERASE_BLOCK, OP_ERASE_CHIP};
      unique case (stageKind_reg)
        OP_ERASE_BLOCK: arrayEraseKind <= ERASE_BLOCK;
        OP_ERASE_CHIP: arrayEraseKind <= ERASE_CHIP;
        default: arrayEraseKind <= ERASE_SECTOR;
      endcase
      if (stageValid_reg) begin
        unique case (stageKind_reg)
          OP_READ: respData <= arrayRdData;
          OP_SEC_READ: respData <= secMem[secIndex(arrayAddr_reg)];
          OP_PARAM_READ: respData <= paramByte(arrayAddr_reg[7:0]);
          default: respData <= 8'h00;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Security regions
  // --------------------------------------------------------------------------
  logic [11:0] eraseIdx_reg;
  logic busy_reg;

  // One byte per cycle keeps the erase to a single write port on the array
  always_ff @(posedge clock) begin
    if (rst || resetFire) begin
      busy_reg <= 1'b0;
      eraseIdx_reg <= 12'h000;
    end else if (busy_reg) begin
      eraseIdx_reg <= eraseIdx_reg + 12'h001;
      if (eraseIdx_reg[9:0] == 10'h3ff) begin
        busy_reg <= 1'b0;
      end
    end else if (stageGo && stageKind_reg == OP_SEC_ERASE) begin
      busy_reg <= 1'b1;
      eraseIdx_reg <= {arrayAddr_reg[13:12] - 2'h1, 10'h000};
    end
  end

  assign busy = busy_reg;

  // Cycles spent busy so far; only the erase length assertions read it
  logic [10:0] busyLen_reg;

  always_ff @(posedge clock) begin
    if (rst || !busy_reg) begin
      busyLen_reg <= 11'h000;
    end else if (busyLen_reg != 11'h7ff) begin
      busyLen_reg <= busyLen_reg + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (busy_reg && !resetFire) begin
      secMem[eraseIdx_reg] <= `SFRAM_ERASED_BYTE;
    end else if (stageGo && stageKind_reg == OP_SEC_PROGRAM) begin
      secMem[secIndex(arrayAddr_reg)] <= secMem[secIndex(arrayAddr_reg)] & stageData_reg;
    end
  end

  // Lock bits survive a pin reset; only power-on clears them
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_reg <= 3'h0;
    end else if (stageGo && stageKind_reg == OP_SEC_LOCK) begin
      lock_reg[arrayAddr_reg[13:12]] <= 1'b1;
    end
  end

  assign lockState = lock_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqTake(sfram_opkind_e k);
    opValid && opReady && opKind == k;
  endsequence

  sequence seqRefused;
    ##1 respValid && respError;
  endsequence

  AST_RESET_SEL_DEFAULT: assert property ($fell(rst) |-> !resetPinSelect)
    else $error("reset select not cleared by reset");
  AST_RESET_ABORT: assert property (hwResetLow && resetLowCnt_reg == 16'(RESET_LOW_CYCLES - 1)
      |=> abortPulse && state_reg == ST_RESET_HELD && !respValid)
    else $error("long reset low did not abort");
  AST_QUAD_NO_RESET: assert property (quadEnable |-> !holdActive && !hwResetLow)
    else $error("line three used as control in quad mode");
  AST_HOLD_FLOAT: assert property (holdActive |-> !dataOutEn && !opReady)
    else $error("output or input active during hold");
  AST_PROGRAM_CLEARS_ONLY: assert property (arrayWrEn |-> (arrayWrData & ~$past(arrayRdData)) == 8'h00)
    else $error("program would set a bit");
  AST_PAGE_ERASE_REFUSED: assert property (seqTake(OP_ERASE_PAGE) ##1 !resetFire |-> ##1 respValid && respError
      && !arrayErase)
    else $error("page erase not refused");
  AST_SECTOR_BASE: assert property (arrayErase |-> arraySector == arrayAddr[23:12])
    else $error("sector index mismatch");
  AST_LOCKED_REFUSED: assert property (opValid && opReady && opKind == OP_SEC_PROGRAM && regionLocked
      ##1 !resetFire |-> seqRefused)
    else $error("locked region program not refused");
  AST_PARAM_READ_ONLY: assert property (seqTake(OP_PARAM_READ) |-> ##1 !arrayWrEn ##1 !arrayWrEn)
    else $error("parameter read caused a write");
  AST_FRESH_SELECT: assert property (state_reg == ST_RESET_HELD && !hwResetLow && !resetFire
      |=> state_reg == ST_WAIT_DESELECT && !opReady)
    else $error("select accepted without fresh falling edge");
  AST_WAIT_NO_READY: assert property (state_reg != ST_SELECTED |-> !opReady)
    else $error("ready while not freshly selected");
  AST_ERASE_LENGTH: assert property ($fell(busy) && !$past(resetFire)
      |-> $past(busyLen_reg) == 11'(`SFRAM_REGION_BYTES - 1))
    else $error("region erase length wrong");
  AST_ERASE_BOUND: assert property (busy |-> busyLen_reg <= 11'(`SFRAM_REGION_BYTES - 1))
    else $error("region erase ran too long");

endmodule // sfram_core

// >>> test/sfram_mem_model.sv
// Behavioural main-array byte store on the far side of the flash map core
`timescale 1ns/1ps

module sfram_mem_model (
  input wire logic clock, // System clock
  input wire logic [23:0] arrayAddr, // Byte address from the core
  output logic [7:0] arrayRdData, // Byte at arrayAddr
  input wire logic arrayWrEn, // Byte write pulse
  input wire logic [7:0] arrayWrData // Byte to store
);
  // Only the low address byte indexes the store, so tests keep their low bytes distinct
  logic [7:0] mem [0:255];

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hff;
  end

  assign arrayRdData = mem[arrayAddr[7:0]];

  always @(posedge clock) begin
    if (arrayWrEn) mem[arrayAddr[7:0]] <= arrayWrData;
  end
endmodule // sfram_mem_model

// >>> test/sfram_core_tb.sv
// Self-checking bench for the flash map core
`timescale 1ns/1ps

module sfram_core_tb;
  import sfram_pkg::*;
  logic clock = 0, rst = 1, csN = 0, dataLineThreeIn = 1, cfgWrite = 0, cfgResetPinSelect = 0, cfgQuadEnable = 0;
  logic opValid = 0;
  sfram_opkind_e opKind = OP_READ;
  logic [23:0] opAddr = 24'h000000;
  logic [7:0] opData = 8'h00;
  logic opReady, respValid, respError, arrayWrEn, arrayErase, abortPulse, holdActive, dataOutEn, busy;
  logic resetPinSelect, quadEnable;
  logic [7:0] respData, arrayRdData, arrayWrData, arrayBlock;
  logic [23:0] arrayAddr;
  logic [11:0] arraySector;
  logic [15:0] arrayPage;
  logic [3:1] lockState;
  sfram_erase_e arrayEraseKind;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  logic [7:0] rData;
  logic rErr, rWr, rEr;
  logic [7:0] rWrData;
  sfram_erase_e rEk;

  always #25 clock = ~clock;

  sfram_core #(.RESET_LOW_CYCLES(3)) DUT (.clock(clock), .rst(rst), .csN(csN), .dataLineThreeIn(dataLineThreeIn),
    .cfgWrite(cfgWrite), .cfgResetPinSelect(cfgResetPinSelect), .cfgQuadEnable(cfgQuadEnable), .opValid(opValid),
    .opKind(opKind), .opAddr(opAddr), .opData(opData), .opReady(opReady), .respValid(respValid), .respData(respData),
    .respError(respError), .arrayAddr(arrayAddr), .arrayRdData(arrayRdData), .arrayWrEn(arrayWrEn),
    .arrayWrData(arrayWrData), .arrayErase(arrayErase), .arrayEraseKind(arrayEraseKind), .arrayBlock(arrayBlock),
    .arraySector(arraySector), .arrayPage(arrayPage), .abortPulse(abortPulse), .holdActive(holdActive),
    .dataOutEn(dataOutEn), .busy(busy), .lockState(lockState), .resetPinSelect(resetPinSelect),
    .quadEnable(quadEnable));

  sfram_mem_model memModel (.clock(clock), .arrayAddr(arrayAddr), .arrayRdData(arrayRdData), .arrayWrEn(arrayWrEn),
    .arrayWrData(arrayWrData));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic cfg(input logic r, input logic q);
    @(negedge clock);
    cfgWrite = 1;
    cfgResetPinSelect = r;
    cfgQuadEnable = q;
    @(negedge clock);
    cfgWrite = 0;
  endtask

  // A fresh falling edge of chip select is needed after any reset
  task automatic sel();
    @(negedge clock);
    csN = 1;
    @(negedge clock);
    csN = 0;
    @(negedge clock);
  endtask

  task automatic op(input sfram_opkind_e k, input logic [23:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rErr = 1'bx; rWr = 0; rEr = 0;
    opValid = 1; opKind = k; opAddr = a; opData = d;
    while (opReady !== 1'b1 && n < 1200) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    opValid = 0;
    for (n = 0; n < 4 && respValid !== 1'b1; n++) @(negedge clock);
    chk(respValid, 1'b1, "answer seen");
    rData = respData; rErr = respError; rWr = arrayWrEn; rWrData = arrayWrData; rEr = arrayErase;
    rEk = arrayEraseKind;
  endtask

  task automatic idle_wait();
    for (int n = 0; n < 1100 && busy !== 1'b0; n++) @(negedge clock);
    chk(busy, 1'b0, "erase finished");
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_state();
    chk({resetPinSelect, quadEnable, lockState}, 5'h00, "config after reset");
    // Select has stayed low across reset, so no falling edge has been seen
    @(negedge clock);
    chk(opReady, 1'b0, "select without falling edge");
    sel();
    chk(opReady, 1'b1, "ready after falling edge");
  endtask

  task automatic t_array();
    memModel.mem[8'h23] = 8'hf0;
    op(OP_PROGRAM, 24'hfef123, 8'h3c);
    chk({rErr, rWr, rWrData}, 10'h130, "program clears bits only");
    chk({arrayBlock, arraySector, arrayPage}, 36'hfe_fef_fef1, "address fields");
    chk(arraySector, 12'hfef, "sector of top address");
    chk(arrayPage, 16'hfef1, "page of top address");
    op(OP_READ, 24'hfef123, 8'h00);
    chk({rErr, rData}, 9'h030, "read back");
    op(OP_ERASE_SECTOR, 24'h02f000, 8'h00);
    chk({rErr, rEr, rEk}, {2'b01, ERASE_SECTOR}, "sector erase");
    op(OP_ERASE_BLOCK, 24'h020000, 8'h00);
    chk({rErr, rEr, rEk}, {2'b01, ERASE_BLOCK}, "block erase");
    op(OP_ERASE_CHIP, 24'h000000, 8'h00);
    chk({rErr, rEr, rEk}, {2'b01, ERASE_CHIP}, "chip erase");
    op(OP_ERASE_PAGE, 24'h010100, 8'h00);
    chk({rErr, rEr}, 2'b10, "page erase refused");
  endtask

  task automatic t_param();
    logic [23:0] adr [6] = '{24'h0, 24'h0c, 24'h20, 24'h30, 24'h7b, 24'h7c};
    logic [7:0] exp [6] = '{8'h53, 8'h30, 8'hff, 8'hff, 8'hff, 8'hff};
    for (int i = 0; i < 6; i++) begin
      op(OP_PARAM_READ, adr[i], 8'h00);
      chk({rErr, rData}, {1'b0, exp[i]}, "parameter byte");
    end
    op(OP_PARAM_READ, 24'h000100, 8'h00);
    chk(rErr, 1'b1, "parameter space ends at ff");
    op(OP_PROGRAM, 24'h000044, 8'h00);
    op(OP_PARAM_READ, 24'h000044, 8'h00);
    chk(rData, 8'hff, "parameter space separate from array");
  endtask

  task automatic t_regions();
    op(OP_SEC_ERASE, 24'h001000, 8'h00);
    idle_wait();
    op(OP_SEC_PROGRAM, 24'h001005, 8'ha5);
    op(OP_SEC_READ, 24'h001005, 8'h00);
    chk({rErr, rData}, 9'h0a5, "region one data");
    op(OP_SEC_READ, 24'h0013ff, 8'h00);
    chk({rErr, rData}, 9'h0ff, "region one top byte erased");
    op(OP_SEC_READ, 24'h001400, 8'h00);
    chk(rErr, 1'b1, "past region one");
    op(OP_SEC_READ, 24'h0033ff, 8'h00);
    chk(rErr, 1'b0, "region three top");
    op(OP_SEC_LOCK, 24'h001000, 8'h00);
    chk(lockState, 3'b001, "region one locked only");
    op(OP_SEC_PROGRAM, 24'h001006, 8'h00);
    chk(rErr, 1'b1, "locked program refused");
    op(OP_SEC_ERASE, 24'h001000, 8'h00);
    chk({rErr, busy}, 2'b10, "locked erase refused");
    op(OP_SEC_ERASE, 24'h002000, 8'h00);
    chk({rErr, busy}, 2'b01, "region two still erasable");
    idle_wait();
  endtask

  task automatic t_hold();
    cfg(1'b0, 1'b0);
    dataLineThreeIn = 0;
    @(negedge clock);
    chk({holdActive, dataOutEn, opReady}, 3'b100, "hold floats output");
    dataLineThreeIn = 1;
    @(negedge clock);
    chk({holdActive, opReady}, 2'b01, "hold released");
    cfg(1'b1, 1'b1);
    dataLineThreeIn = 0;
    repeat (6) @(negedge clock);
    chk({holdActive, abortPulse, opReady}, 3'b001, "quad mode line is data");
    dataLineThreeIn = 1;
  endtask

  // Host keeps the line low one cycle past the minimum time, csN high, mid region erase
  task automatic t_pin_reset();
    int n;
    cfg(1'b1, 1'b0);
    op(OP_SEC_ERASE, 24'h003000, 8'h00);
    chk(busy, 1'b1, "erase running");
    csN = 1;
    dataLineThreeIn = 0;
    for (n = 0; n < 10 && abortPulse !== 1'b1; n++) @(negedge clock);
    chk(abortPulse, 1'b1, "abort pulse");
    chk(n, 3, "abort exactly at minimum low time");
    @(negedge clock);
    chk({abortPulse, busy}, 2'b00, "erase aborted");
    dataLineThreeIn = 1;
    @(negedge clock);
    csN = 0;
    repeat (2) @(negedge clock);
    chk(opReady, 1'b0, "no instruction before fresh select");
    sel();
    chk(opReady, 1'b1, "ready after fresh select");
    cfg(1'b0, 1'b0);
    csN = 1;
    dataLineThreeIn = 0;
    repeat (8) @(negedge clock);
    chk(abortPulse, 1'b0, "hold mode never aborts");
    dataLineThreeIn = 1;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 0;
    t_reset_state();
    t_array();
    t_param();
    t_regions();
    t_hold();
    t_pin_reset();
    wrap_up();
  end
endmodule // sfram_core_tb
